// File: inc/event_remap_defines.svh
`ifndef EVENT_REMAP_DEFINES_SVH
`define EVENT_REMAP_DEFINES_SVH

// Register byte offsets
`define EVT_CTRL_OFFSET      12'h000
`define REMAP_CFG_OFFSET     12'h004

// Event output control fields
`define EVT_ENABLE_BIT       7
`define EVT_PORT_MSB         6
`define EVT_PORT_LSB         4
`define EVT_PIN_MSB          3
`define EVT_PIN_LSB          0
`define EVT_CTRL_RESET       8'h00

// Remap configuration fields
`define TMR1_SRC_BIT         29
`define SPI2_ALT_BIT         28
`define DBG_SEL_MSB          26
`define DBG_SEL_LSB          24
`define TMR1_SRC_RESET       1'h0
`define SPI2_ALT_RESET       1'h0
`define DBG_SEL_RESET        3'h0

// Debug port select codes
`define DBG_BOTH_ON          3'h0
`define DBG_SWD_ONLY         3'h2
`define DBG_ALL_OFF          3'h4

// Port count and pins per port
`define NUM_PORTS            5
`define PINS_PER_PORT        16

`endif

// File: inc/event_remap_pkg.sv
`default_nettype none
package event_remap_pkg;

    // Event output control fields
    typedef struct packed {
        logic       enable;
        logic [2:0] port;
        logic [3:0] pin;
    } evt_ctrl_t;

    // Remap configuration fields held in flip-flops
    typedef struct packed {
        logic       tmr1_src;
        logic       spi2_alt;
        logic [2:0] dbg_sel;
    } remap_cfg_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // Decoded debug port state
    typedef struct packed {
        logic jtag_en;
        logic swd_en;
    } dbg_ports_t;

endpackage
`default_nettype wire

// File: rtl/event_out_and_remap_config.sv
// Behaviour
// - With the enable bit set, the core event signal drives the selected pin.
// - Port codes 000 to 100 select ports A to E in order.
// - The four-bit pin field is a binary pin index 0 to 15.
// - The debug port select field is write-only and reads as zero.
// - Debug codes 000 both on, 010 serial-wire only, 100 both off.
// - The SPI unit two alternate bit moves all its signals to the alt pins.
// - The timer one source bit feeds USB start-of-frame to timer one input.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "event_remap_defines.svh"

module event_out_and_remap_config
(
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    input  wire logic                        clk_en,
    input  wire event_remap_pkg::apb_req_t   apb_req,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        core_event_signal,
    input  wire logic                        usb_sof_pulse,
    input  wire logic                        timer_one_ext_input,
    output logic [79:0]                      event_pin_out,
    output logic [79:0]                      event_pin_oe,
    output logic                             spi_unit_two_alt_pins,
    output logic                             timer_one_input_one,
    output event_remap_pkg::dbg_ports_t      dbg_ports
);
    import event_remap_pkg::*;

    evt_ctrl_t   evt_reg;
    remap_cfg_t  remap_reg;
    logic [31:0] prdata_reg;
    logic [31:0] read_word;
    logic        wr_stb;
    logic        setup_rd;
    logic        hit_evt;
    logic        hit_remap;

    // Access strobes; slave answers with no wait state
    assign wr_stb = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
    assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite
                    & clk_en;
    assign pready = 1'b1;

    // Address decode
    always_comb
    begin
        hit_evt   = 1'b0;
        hit_remap = 1'b0;
        if (apb_req.paddr == `EVT_CTRL_OFFSET)
            hit_evt = 1'b1;
        else if (apb_req.paddr == `REMAP_CFG_OFFSET)
            hit_remap = 1'b1;
    end

    // Event control register; reserved bits are not stored
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            evt_reg <= evt_ctrl_t'(`EVT_CTRL_RESET);
        else if (wr_stb && hit_evt)
        begin
            evt_reg.enable <= apb_req.pwdata[`EVT_ENABLE_BIT];
            evt_reg.port   <= apb_req.pwdata[`EVT_PORT_MSB:`EVT_PORT_LSB];
            evt_reg.pin    <= apb_req.pwdata[`EVT_PIN_MSB:`EVT_PIN_LSB];
        end
    end

    // Remap configuration register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            remap_reg.tmr1_src <= `TMR1_SRC_RESET;
            remap_reg.spi2_alt <= `SPI2_ALT_RESET;
            remap_reg.dbg_sel  <= `DBG_SEL_RESET;
        end
        else if (wr_stb && hit_remap)
        begin
            remap_reg.tmr1_src <= apb_req.pwdata[`TMR1_SRC_BIT];
            remap_reg.spi2_alt <= apb_req.pwdata[`SPI2_ALT_BIT];
            remap_reg.dbg_sel  <= apb_req.pwdata[`DBG_SEL_MSB:`DBG_SEL_LSB];
        end
    end

    // Read word of the addressed register; reserved bits and the
    // write-only debug field always read as zero
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (hit_evt)
            read_word[7:0] = evt_reg;
        else if (hit_remap)
        begin
            read_word[`TMR1_SRC_BIT] = remap_reg.tmr1_src;
            read_word[`SPI2_ALT_BIT] = remap_reg.spi2_alt;
        end
    end

    // Read data flop is loaded in the setup phase, so it stands through
    // the access phase with no wait state; a read set up while the clock
    // enable is low returns the word last captured
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            prdata_reg <= 32'h0000_0000;
        else if (setup_rd)
            prdata_reg <= read_word;
    end

    // Read data output
    assign prdata = prdata_reg;

    // Unmapped addresses answer with an error in the access phase
    assign pslverr = apb_req.psel & apb_req.penable & ~hit_evt & ~hit_remap;

    // Event routing: flat index is port*16+pin, ports A..E in order
    always_comb
    begin
        event_pin_out = 80'h0;
        event_pin_oe  = 80'h0;
        if (evt_reg.enable && (evt_reg.port < 3'(`NUM_PORTS)))
        begin
            event_pin_out[{evt_reg.port, evt_reg.pin}] = core_event_signal;
            event_pin_oe[{evt_reg.port, evt_reg.pin}]  = 1'b1;
        end
    end

    // SPI unit two pin set select
    assign spi_unit_two_alt_pins = remap_reg.spi2_alt;

    // Timer one input source
    assign timer_one_input_one = remap_reg.tmr1_src ? usb_sof_pulse
                                                    : timer_one_ext_input;

    // Debug port decode; undefined codes keep both ports on
    always_comb
    begin
        dbg_ports.jtag_en = 1'b1;
        dbg_ports.swd_en  = 1'b1;
        case (remap_reg.dbg_sel)
            `DBG_SWD_ONLY:
            begin
                dbg_ports.jtag_en = 1'b0;
            end
            `DBG_ALL_OFF:
            begin
                dbg_ports.jtag_en = 1'b0;
                dbg_ports.swd_en  = 1'b0;
            end
            default:
            begin
                dbg_ports.jtag_en = 1'b1;
            end
        endcase
    end

    // Disabled output drives no pin
    a_evt_off_quiet: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !evt_reg.enable |-> (event_pin_oe == 80'h0))
        else $error("event pin driven while disabled");

    // Disabled output leaves every pin value low
    a_evt_out_zero: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !evt_reg.enable |-> (event_pin_out == 80'h0))
        else $error("event pin value while disabled");

    // Enabled output reaches exactly the selected pin
    a_evt_routes_pin: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (evt_reg.enable && evt_reg.port <= 3'h4) |->
        (event_pin_oe[{evt_reg.port, evt_reg.pin}] &&
         event_pin_out[{evt_reg.port, evt_reg.pin}] == core_event_signal
         && $onehot(event_pin_oe)))
        else $error("event not on selected pin");

    // Port code 100 with pin 15 reaches the last pin
    a_port_e_pin15: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (evt_reg.enable && evt_reg.port == 3'h4 && evt_reg.pin == 4'hF)
        |-> event_pin_oe[79])
        else $error("port E pin 15 not selected");

    // Port codes above 100 select no pin
    a_port_range: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (evt_reg.enable && evt_reg.port > 3'h4) |-> (event_pin_oe == 80'h0))
        else $error("pin driven for undefined port");

    // Pin field is a binary index within port A
    a_pin_index: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (evt_reg.enable && evt_reg.port == 3'h0) |->
        event_pin_oe[15:0] == (16'h0001 << evt_reg.pin))
        else $error("pin index wrong");

    // Pin field is a binary index within port E
    a_pin_index_e: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (evt_reg.enable && evt_reg.port == 3'h4) |->
        event_pin_oe[79:64] == (16'h0001 << evt_reg.pin))
        else $error("port E pin index wrong");

    // A write to the control register lands on the next edge
    a_evt_write: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (wr_stb && hit_evt) |=> evt_reg == $past(apb_req.pwdata[7:0]))
        else $error("event control write lost");

    // Control register reads back during the access phase
    a_rd_evt_data: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (apb_req.psel && apb_req.penable && !apb_req.pwrite && hit_evt &&
         $past(clk_en)) |-> prdata == {24'h00_0000, evt_reg})
        else $error("event control read wrong");

    // Remap register reads back only its two readable bits
    a_rd_remap_data: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (apb_req.psel && apb_req.penable && !apb_req.pwrite && hit_remap &&
         $past(clk_en)) |->
        prdata == {2'b00, remap_reg.tmr1_src, remap_reg.spi2_alt,
                   28'h000_0000})
        else $error("remap read wrong");

    // Write-only debug field never shows on the read bus
    a_dbg_readback: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (apb_req.psel && apb_req.penable && hit_remap) |->
        prdata[`DBG_SEL_MSB:`DBG_SEL_LSB] == 3'h0)
        else $error("debug select readable");

    // Code 010 turns off the JTAG port only
    a_dbg_decode: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (wr_stb && hit_remap && apb_req.pwdata[26:24] == `DBG_SWD_ONLY) |=>
        (!dbg_ports.jtag_en && dbg_ports.swd_en))
        else $error("serial-wire only decode wrong");

    // Code 100 turns off both debug ports
    a_dbg_all_off: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (remap_reg.dbg_sel == `DBG_ALL_OFF) |-> (dbg_ports == 2'b00))
        else $error("debug all-off decode wrong");

    // Code 000 keeps both debug ports on
    a_dbg_both_on: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (remap_reg.dbg_sel == `DBG_BOTH_ON) |-> (dbg_ports == 2'b11))
        else $error("debug both-on decode wrong");

    // A write to the remap register sets the debug select field
    a_dbg_write: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (wr_stb && hit_remap) |=>
        remap_reg.dbg_sel == $past(apb_req.pwdata[26:24]))
        else $error("debug select write lost");

    // Alternate pin set follows the written bit
    a_spi_alt: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (wr_stb && hit_remap) |=>
        spi_unit_two_alt_pins == $past(apb_req.pwdata[28]))
        else $error("SPI alt pin select wrong");

    // Source bit set feeds the frame pulse to timer one
    a_tmr_source: assert property (
        @(posedge core_clk) disable iff (!rstn)
        remap_reg.tmr1_src |-> (timer_one_input_one == usb_sof_pulse))
        else $error("timer one source wrong");

    // Source bit clear keeps the external timer input
    a_tmr_default: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !remap_reg.tmr1_src |->
        (timer_one_input_one == timer_one_ext_input))
        else $error("timer one default source wrong");

    // A write to the remap register sets the timer source bit
    a_tmr_write: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (wr_stb && hit_remap) |=>
        remap_reg.tmr1_src == $past(apb_req.pwdata[29]))
        else $error("timer source write lost");

    // Clock enable low freezes both registers
    a_hold_frozen: assert property (
        @(posedge core_clk) disable iff (!rstn)
        !clk_en |=> ($stable(evt_reg) && $stable(remap_reg)))
        else $error("register changed while frozen");

    // Unmapped access answers with an error
    a_miss_error: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (apb_req.psel && apb_req.penable && !hit_evt && !hit_remap) |->
        pslverr)
        else $error("unmapped access without error");

    // Unmapped write changes no register
    a_miss_no_write: assert property (
        @(posedge core_clk) disable iff (!rstn)
        (wr_stb && !hit_evt && !hit_remap) |=>
        ($stable(evt_reg) && $stable(remap_reg)))
        else $error("unmapped write changed a register");

endmodule
`default_nettype wire

// File: testbench/event_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module event_far_side
(
    input  wire logic core_clk,
    input  wire logic rstn,
    output logic      core_event_signal,
    output logic      usb_sof_pulse,
    output logic      timer_one_ext_input
);
    logic [2:0] cnt_reg;
    // Phase counter behind the core-side stimuli
    always_ff @(posedge core_clk)
        cnt_reg <= rstn ? cnt_reg + 3'h1 : 3'h0;
    // Event toggles each cycle, frame pulse once in eight
    assign core_event_signal   = cnt_reg[0];
    assign usb_sof_pulse       = (cnt_reg == 3'h7);
    assign timer_one_ext_input = cnt_reg[1];
endmodule
`default_nettype wire

// File: testbench/event_out_and_remap_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module event_out_and_remap_config_tb;
    import event_remap_pkg::*;
    logic        core_clk, rstn, clk_en, pready, pslverr, err;
    logic        ev, sof, ext, spi, t1i;
    logic [31:0] prdata, rd, w;
    logic [79:0] pin_out, pin_oe;
    logic [7:0]  c;
    apb_req_t    req;
    dbg_ports_t  dbg;
    int          error_cnt, compares, cyc;
    logic [7:0]  corner [6] = '{8'h9F, 8'hCF, 8'h80, 8'h4F, 8'hFF, 8'hB3};
    logic [2:0]  dcode [4] = '{3'h0, 3'h2, 3'h4, 3'h1};

    event_far_side far (.core_clk(core_clk), .rstn(rstn),
        .core_event_signal(ev), .usb_sof_pulse(sof),
        .timer_one_ext_input(ext));
    event_out_and_remap_config dut (.core_clk(core_clk), .rstn(rstn),
        .clk_en(clk_en), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_event_signal(ev), .usb_sof_pulse(sof),
        .timer_one_ext_input(ext), .event_pin_out(pin_out),
        .event_pin_oe(pin_oe), .spi_unit_two_alt_pins(spi),
        .timer_one_input_one(t1i), .dbg_ports(dbg));

    // Clock generator
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task report_and_stop();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One comparison
    task chk(input string n, input logic [79:0] e, input logic [79:0] g);
        compares++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
        @(posedge core_clk);
    endtask

    // Expected one-hot pin enable for a control byte
    function logic [79:0] exp_oe(input logic [7:0] v);
        exp_oe = '0;
        if (v[7] && v[6:4] < 3'h5)
            exp_oe[{v[6:4], v[3:0]}] = 1'b1;
    endfunction

    // Expected debug port state for a select code
    function dbg_ports_t exp_dbg(input logic [2:0] s);
        exp_dbg = (s == 3'h2) ? 2'b01 : (s == 3'h4) ? 2'b00 : 2'b11;
    endfunction

    // Hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // Main sequence
    initial
    begin
        req = '0;
        clk_en = 1'b1;
        rstn = 1'b0;
        void'($urandom(82590));
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_rst", 0, rd);
        chk("rd_ok", 0, err);
        chk("pready", 1, pready);
        apb(1'b0, 12'h004, 32'h0);
        chk("remap_rst", 0, rd);
        #1;
        chk("dbg_rst", 2'b11, dbg);
        chk("oe_rst", 0, pin_oe);
        chk("tmr_rst", ext, t1i);
        @(posedge core_clk);
        for (int i = 0; i < 24; i++)
        begin
            c = (i < 6) ? corner[i] : 8'($urandom);
            apb(1'b1, 12'h000, {24'h0, c});
            apb(1'b0, 12'h000, 32'h0);
            chk("ctrl", {24'h0, c}, rd);
            #1;
            chk("pin_oe", exp_oe(c), pin_oe);
            chk("pin_out", exp_oe(c) & {80{ev}}, pin_out);
            @(posedge core_clk);
        end
        for (int i = 0; i < 8; i++)
        begin
            w = {2'b0, i[0], i[2], 1'b0, dcode[i[1:0]], 24'h0};
            apb(1'b1, 12'h004, w);
            apb(1'b0, 12'h004, 32'h0);
            chk("remap", w & 32'h3000_0000, rd);
            #1;
            chk("dbg", exp_dbg(w[26:24]), dbg);
            chk("spi_alt", w[28], spi);
            chk("tmr_in", w[29] ? sof : ext, t1i);
            @(posedge core_clk);
        end
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        chk("slverr", 1'b1, err);
        apb(1'b0, 12'h008, 32'h0);
        chk("rd_slverr", 1'b1, err);
        clk_en <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000_0081);
        clk_en <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("frozen", {24'h0, c}, rd);
        report_and_stop();
    end
endmodule
`default_nettype wire
